// File: core/ihw_ctrl.sv
module ihw_ctrl
	import ihw_pkg::*;
#(
	parameter int NSRC = ihw_pkg::NUM_SRC,
	parameter int WARM_SHORT = ihw_pkg::WARM_SHORT_CYC,
	parameter int WARM_LONG = ihw_pkg::WARM_LONG_CYC,
	parameter int DOUBLER = ihw_pkg::DOUBLER_CYC
) (
	input wire logic clk_i, // System clock
	input wire logic rst_i, // Sync reset, high
	input wire logic [31:0] wb_adr_i, // Wishbone address
	input wire logic [31:0] wb_dat_i, // Wishbone write data
	output logic [31:0] wb_dat_o, // Wishbone read data
	input wire logic wb_we_i, // Write enable
	input wire logic [3:0] wb_sel_i, // Byte selects
	input wire logic wb_cyc_i, // Cycle
	input wire logic wb_stb_i, // Strobe
	output logic wb_ack_o, // Acknowledge
	input wire logic nmi_pin_i, // Async non-maskable pin
	input wire logic [NSRC-1:0] irq_pin_i, // Async request lines, 0 is wake pin zero
	input wire logic halt_exec_i, // CPU executes halt
	input wire logic set_mask_i, // CPU executes set-mask
	input wire logic [2:0] set_mask_val_i, // Set-mask operand
	input wire logic mask_all_i, // CPU executes mask-all
	input wire logic sw_irq_i, // Software interrupt
	input wire logic [2:0] sw_num_i, // Software interrupt number
	input wire logic illegal_i, // Illegal instruction
	input wire logic vec_read_i, // CPU reads vector, starts acceptance
	input wire logic first_instr_done_i, // First handler instruction done
	input wire logic return_from_interrupt_instruction_i, // Return from interrupt
	input wire logic [2:0] return_from_interrupt_instruction_mask_i, // Mask restored from stack
	output logic irq_req_o, // Acceptable request for CPU
	output logic [2:0] irq_level_o, // Presented level
	output logic [7:0] vector_o, // Vector value
	output logic [23:0] vector_addr_o, // Vector table address
	output logic push_ctx_o, // Push PC and status pulse
	output logic pop_ctx_o, // Restore PC and status pulse
	output logic [2:0] interrupt_mask_level_o, // Current mask
	output logic [7:0] nesting_counter_o, // Nesting depth
	output logic cpu_run_o, // CPU may execute
	output logic sys_clk_en_o, // System clock gate
	output logic osc_en_o, // Oscillator enable
	output logic periph_run_o, // Peripherals run
	output logic pin_drive_en_o, // Output pins enabled
	output logic resume_o // Resume after halt pulse
);
	import ihw_pkg::*;

	typedef enum logic [4:0] {
		IHW_RUN = 5'h01,
		IHW_PIDLE = 5'h02,
		IHW_CIDLE = 5'h04,
		IHW_STOP = 5'h08,
		IHW_WARM = 5'h10
	} ihw_state_t;
	localparam int IW = $clog2(NSRC);

	function automatic logic [2:0] mask_of(input logic [2:0] v);
		mask_of = (v == LEVEL_MIN) ? 3'h1 : v;
	endfunction

	// Two-flop synchronisers
	logic [NSRC:0] sync1_reg, sync2_reg, sync3_reg;
	logic [NSRC:0] sync1_next, sync2_next, sync3_next;
	logic nmi_s, nmi_rise;
	logic [NSRC-1:0] irq_s, irq_rise;
	always_comb begin
		sync1_next = {nmi_pin_i, irq_pin_i};
		sync2_next = sync1_reg;
		sync3_next = sync2_reg;
	end
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			sync1_reg <= '0;
			sync2_reg <= '0;
			sync3_reg <= '0;
		end else begin
			sync1_reg <= sync1_next;
			sync2_reg <= sync2_next;
			sync3_reg <= sync3_next;
		end
	end
	assign nmi_s = sync2_reg[NSRC];
	assign irq_s = sync2_reg[NSRC-1:0];
	assign nmi_rise = nmi_s & ~sync3_reg[NSRC];
	assign irq_rise = irq_s & ~sync3_reg[NSRC-1:0];

	// Registers
	logic [7:0] ctrl_reg, ctrl_next;
	logic [3*NSRC-1:0] prio_reg, prio_next;
	logic [NSRC-1:0] pend_reg, pend_next;
	logic nmi_pend_reg, nmi_pend_next;
	logic [2:0] mask_reg, mask_next;
	logic [7:0] nest_reg, nest_next;
	logic accepting_reg, accepting_next;
	logic ack_reg, ack_next;
	logic [31:0] rdat_reg, rdat_next;
	ihw_state_t state_reg, state_next;
	logic [CNT_W-1:0] cnt_reg, cnt_next;
	logic phase_reg, phase_next;
	logic req_reg, req_next;
	logic [2:0] lvl_reg, lvl_next;
	logic [7:0] vec_reg, vec_next;
	logic [23:0] vaddr_reg, vaddr_next;
	logic push_reg, push_next, pop_reg, pop_next, resume_reg, resume_next;
	logic run_reg, run_next, clk_reg, clk_next, osc_reg, osc_next;
	logic per_reg, per_next, drv_reg, drv_next;

	logic found;
	logic [2:0] res_level;
	logic [IW-1:0] res_idx;
	ihw_prio_resolve #(.N(NSRC)) u_resolve (
		.pend_i(pend_reg),
		.level_i(prio_reg),
		.found_o(found),
		.level_o(res_level),
		.idx_o(res_idx)
	);

	logic wb_req, wb_wr, wr_ctrl, wr_prio, wr_pend;
	logic mask_ok, wake_any, stop_wake, take;
	logic [2:0] acc_level;
	assign wb_req = wb_cyc_i & wb_stb_i & ~ack_reg;
	// Writes land on the edge at which the master sees ack
	assign wb_wr = wb_cyc_i & wb_stb_i & wb_we_i & ack_reg;
	assign wr_ctrl = wb_wr & wb_sel_i[0] & (wb_adr_i[3:0] == ADDR_CTRL);
	assign wr_prio = wb_wr & (wb_adr_i[3:0] == ADDR_PRIO);
	assign wr_pend = wb_wr & wb_sel_i[0] & (wb_adr_i[3:0] == ADDR_PEND);
	assign mask_ok = found && res_level >= mask_reg;
	// Requests are not taken while an acceptance is in progress
	assign take = ~accepting_reg & (nmi_pend_reg | mask_ok);
	assign wake_any = nmi_pend_reg | mask_ok | pend_reg[0];
	assign stop_wake = nmi_pend_reg | pend_reg[0];
	assign acc_level = nmi_pend_reg ? LEVEL_MAX : res_level;

	// Register file and interrupt flags
	always_comb begin
		ctrl_next = ctrl_reg;
		prio_next = prio_reg;
		pend_next = pend_reg;
		nmi_pend_next = nmi_pend_reg;
		ack_next = wb_req;
		rdat_next = rdat_reg;
		if (wr_ctrl)
			ctrl_next = wb_dat_i[7:0];
		for (int b = 0; b < 3; b++) begin
			if (wr_prio && wb_sel_i[b])
				prio_next[8*b +: 8] = wb_dat_i[8*b +: 8];
		end
		if (wr_pend) begin
			pend_next = pend_reg & ~wb_dat_i[NSRC-1:0];
			nmi_pend_next = nmi_pend_reg & ~wb_dat_i[NSRC];
		end
		if (vec_read_i && !accepting_reg) begin
			if (nmi_pend_reg)
				nmi_pend_next = 1'b0;
			else if (mask_ok)
				pend_next[res_idx] = 1'b0;
		end
		// Set beats clear
		pend_next = pend_next | irq_rise;
		nmi_pend_next = nmi_pend_next | nmi_rise;
		if (state_reg == IHW_PIDLE && |irq_rise[NSRC-1:5]) begin
			ctrl_next[F_TMR8_RUN] = 1'b1;
			ctrl_next[F_TMRA_RUN] = 1'b1;
		end
		if (wb_req && !wb_we_i) begin
			case (wb_adr_i[3:0])
				ADDR_CTRL: rdat_next = {24'h000000, ctrl_reg};
				ADDR_PRIO: rdat_next = {8'h00, prio_reg};
				ADDR_STATUS: rdat_next = {16'h0000, nest_reg, 3'h0, state_reg};
				ADDR_PEND: rdat_next = {23'h000000, nmi_pend_reg, pend_reg};
				default: rdat_next = 32'h00000000;
			endcase
		end
	end

	// Mask, nesting and acceptance
	always_comb begin
		mask_next = mask_reg;
		nest_next = nest_reg;
		accepting_next = accepting_reg;
		push_next = 1'b0;
		pop_next = 1'b0;
		vec_next = vec_reg;
		if (set_mask_i)
			mask_next = mask_of(set_mask_val_i);
		if (mask_all_i)
			mask_next = LEVEL_MAX;
		if (first_instr_done_i)
			accepting_next = 1'b0;
		if (return_from_interrupt_instruction_i) begin
			mask_next = return_from_interrupt_instruction_mask_i;
			nest_next = nest_reg - 8'h01;
			pop_next = 1'b1;
		end else if ((sw_irq_i || illegal_i) && !accepting_reg) begin
			nest_next = nest_reg + 8'h01;
			push_next = 1'b1;
			accepting_next = 1'b1;
			vec_next = illegal_i ? VEC_ILLEGAL : VEC_SWI_BASE + {3'h0, sw_num_i, 2'h0};
		end else if (vec_read_i && take) begin
			mask_next = (acc_level == LEVEL_MAX) ? LEVEL_MAX : acc_level + 3'h1;
			nest_next = nest_reg + 8'h01;
			push_next = 1'b1;
			accepting_next = 1'b1;
			vec_next = nmi_pend_reg ? VEC_NMI : VEC_SRC_BASE + (8'(res_idx) << 2);
		end
	end

	// Standby controller
	always_comb begin
		state_next = state_reg;
		cnt_next = cnt_reg;
		phase_next = phase_reg;
		resume_next = 1'b0;
		case (state_reg)
			IHW_RUN: begin
				if (halt_exec_i) begin
					case (ctrl_reg[F_HALT_MODE +: 2])
						HALT_MODE_PERIPH_IDLE: state_next = IHW_PIDLE;
						HALT_MODE_CLOCK_IDLE: state_next = IHW_CIDLE;
						HALT_MODE_STOP: state_next = IHW_STOP;
						default: state_next = IHW_RUN;
					endcase
				end
			end
			IHW_PIDLE: begin
				if (wake_any) begin
					state_next = IHW_RUN;
					resume_next = 1'b1;
				end
			end
			IHW_CIDLE, IHW_STOP: begin
				if ((state_reg == IHW_CIDLE) ? wake_any : stop_wake) begin
					state_next = IHW_WARM;
					cnt_next = CNT_W'(ctrl_reg[F_WARM_SEL] ? WARM_LONG - 1 : WARM_SHORT - 1);
					phase_next = (state_reg == IHW_STOP);
				end
			end
			IHW_WARM: begin
				if (cnt_reg != '0)
					cnt_next = cnt_reg - 1'b1;
				else if (phase_reg) begin
					phase_next = 1'b0;
					cnt_next = CNT_W'(DOUBLER - 1);
				end else begin
					state_next = IHW_RUN;
					resume_next = 1'b1;
				end
			end
			default: state_next = IHW_RUN;
		endcase
	end

	// Outputs
	always_comb begin
		run_next = (state_next == IHW_RUN);
		clk_next = (state_next == IHW_RUN) || (state_next == IHW_PIDLE);
		osc_next = (state_next != IHW_STOP) && !(state_next == IHW_WARM && phase_next);
		per_next = (state_next == IHW_RUN) ||
			(state_next == IHW_PIDLE && |ctrl_next[F_IDLE_RUN +: 4]);
		drv_next = (state_next != IHW_STOP) || ctrl_reg[F_DRIVE_STOP];
		req_next = take && state_reg == IHW_RUN;
		lvl_next = nmi_pend_reg ? LEVEL_MAX : (found ? res_level : LEVEL_MIN);
		vaddr_next = VECTOR_BASE + {16'h0000, vec_next};
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ctrl_reg <= CTRL_RESET;
			prio_reg <= PRIO_RESET;
			pend_reg <= '0;
			nmi_pend_reg <= 1'b0;
			mask_reg <= MASK_RESET;
			nest_reg <= 8'h00;
			accepting_reg <= 1'b0;
			ack_reg <= 1'b0;
			rdat_reg <= 32'h00000000;
			state_reg <= IHW_RUN;
			cnt_reg <= '0;
			phase_reg <= 1'b0;
			req_reg <= 1'b0;
			lvl_reg <= 3'h0;
			vec_reg <= 8'h00;
			vaddr_reg <= VECTOR_BASE;
			push_reg <= 1'b0;
			pop_reg <= 1'b0;
			resume_reg <= 1'b0;
			run_reg <= 1'b1;
			clk_reg <= 1'b1;
			osc_reg <= 1'b1;
			per_reg <= 1'b1;
			drv_reg <= 1'b1;
		end else begin
			ctrl_reg <= ctrl_next;
			prio_reg <= prio_next;
			pend_reg <= pend_next;
			nmi_pend_reg <= nmi_pend_next;
			mask_reg <= mask_next;
			nest_reg <= nest_next;
			accepting_reg <= accepting_next;
			ack_reg <= ack_next;
			rdat_reg <= rdat_next;
			state_reg <= state_next;
			cnt_reg <= cnt_next;
			phase_reg <= phase_next;
			req_reg <= req_next;
			lvl_reg <= lvl_next;
			vec_reg <= vec_next;
			vaddr_reg <= vaddr_next;
			push_reg <= push_next;
			pop_reg <= pop_next;
			resume_reg <= resume_next;
			run_reg <= run_next;
			clk_reg <= clk_next;
			osc_reg <= osc_next;
			per_reg <= per_next;
			drv_reg <= drv_next;
		end
	end

	assign wb_ack_o = ack_reg;
	assign wb_dat_o = rdat_reg;
	assign irq_req_o = req_reg;
	assign irq_level_o = lvl_reg;
	assign vector_o = vec_reg;
	assign vector_addr_o = vaddr_reg;
	assign push_ctx_o = push_reg;
	assign pop_ctx_o = pop_reg;
	assign interrupt_mask_level_o = mask_reg;
	assign nesting_counter_o = nest_reg;
	assign cpu_run_o = run_reg;
	assign sys_clk_en_o = clk_reg;
	assign osc_en_o = osc_reg;
	assign periph_run_o = per_reg;
	assign pin_drive_en_o = drv_reg;
	assign resume_o = resume_reg;

	property p_reset_mask;
		@(posedge clk_i) $fell(rst_i) |-> interrupt_mask_level_o == 3'h7;
	endproperty
	a_reset_mask: assert property (p_reset_mask) else $error("mask not 7 after reset");
	property p_mask_all;
		@(posedge clk_i) disable iff (rst_i) mask_all_i && !return_from_interrupt_instruction_i && !vec_read_i |=> mask_reg == 3'h7;
	endproperty
	a_mask_all: assert property (p_mask_all) else $error("mask-all failed");
	property p_set_zero;
		@(posedge clk_i) disable iff (rst_i)
			set_mask_i && set_mask_val_i == 3'h0 && !mask_all_i && !return_from_interrupt_instruction_i && !vec_read_i
			|=> mask_reg == 3'h1;
	endproperty
	a_set_zero: assert property (p_set_zero) else $error("set-mask 0 not 1");
	property p_stop_osc;
		@(posedge clk_i) disable iff (rst_i) state_reg == IHW_STOP |-> !osc_en_o && !sys_clk_en_o;
	endproperty
	a_stop_osc: assert property (p_stop_osc) else $error("oscillator runs in stop");
	property p_stop_exit;
		@(posedge clk_i) disable iff (rst_i)
			state_reg == IHW_STOP && !stop_wake && !rst_i |=> state_reg == IHW_STOP;
	endproperty
	a_stop_exit: assert property (p_stop_exit) else $error("stop left without wake");
	property p_cidle_clk;
		@(posedge clk_i) disable iff (rst_i) state_reg == IHW_CIDLE |-> osc_en_o && !sys_clk_en_o;
	endproperty
	a_cidle_clk: assert property (p_cidle_clk) else $error("clock idle gating wrong");
	property p_drive;
		@(posedge clk_i) disable iff (rst_i)
			state_reg == IHW_STOP |-> pin_drive_en_o == ctrl_reg[F_DRIVE_STOP];
	endproperty
	a_drive: assert property (p_drive) else $error("stop pin drive wrong");
	property p_warm_hold;
		@(posedge clk_i) disable iff (rst_i)
			state_reg == IHW_WARM && cnt_reg != '0 && !rst_i |=> state_reg == IHW_WARM && !cpu_run_o;
	endproperty
	a_warm_hold: assert property (p_warm_hold) else $error("warm-up cut short");
	property p_return_from_interrupt_instruction;
		@(posedge clk_i) disable iff (rst_i) return_from_interrupt_instruction_i |=> nest_reg == $past(nest_reg) - 8'h01;
	endproperty
	a_return_from_interrupt_instruction: assert property (p_return_from_interrupt_instruction) else $error("nesting not decremented");
	c_stop: cover property (@(posedge clk_i) state_reg == IHW_STOP ##1 state_reg == IHW_WARM);
	c_pidle: cover property (@(posedge clk_i) state_reg == IHW_PIDLE ##1 state_reg == IHW_RUN);
	c_accept: cover property (@(posedge clk_i) push_ctx_o && !accepting_reg);
	c_return_from_interrupt_instruction: cover property (@(posedge clk_i) pop_ctx_o);
endmodule // ihw_ctrl

// File: shared/ihw_pkg.sv
package ihw_pkg;
	// Halt mode select codes
	localparam logic [1:0] HALT_MODE_PERIPH_IDLE = 2'h3;
	localparam logic [1:0] HALT_MODE_CLOCK_IDLE = 2'h2;
	localparam logic [1:0] HALT_MODE_STOP = 2'h1;
	localparam logic [1:0] HALT_MODE_RESERVED = 2'h0;
	// Priority levels
	localparam logic [2:0] LEVEL_MAX = 3'h7;
	localparam logic [2:0] LEVEL_MIN = 3'h0;
	localparam logic [2:0] MASK_RESET = 3'h7;
	// Vector numbering (vector value = index * 4)
	localparam int NUM_SRC = 8;
	localparam logic [7:0] VEC_SWI_BASE = 8'h00;
	localparam logic [7:0] VEC_ILLEGAL = 8'h08;
	localparam logic [7:0] VEC_NMI = 8'h20;
	localparam logic [7:0] VEC_WAKE0 = 8'h28;
	localparam logic [7:0] VEC_SRC_BASE = 8'h28;
	localparam logic [23:0] VECTOR_BASE = 24'hffff00;
	// Warm-up exponents, in oscillator periods
	localparam int WARM_SHORT_EXP = 15;
	localparam int WARM_LONG_EXP = 17;
	localparam int DOUBLER_EXP = 15;
	localparam int WARM_SHORT_CYC = 2 ** WARM_SHORT_EXP;
	localparam int WARM_LONG_CYC = 2 ** WARM_LONG_EXP;
	localparam int DOUBLER_CYC = 2 ** DOUBLER_EXP;
	localparam int CNT_W = 18;
	// Wishbone register offsets (byte addresses)
	localparam logic [3:0] ADDR_CTRL = 4'h0;
	localparam logic [3:0] ADDR_PRIO = 4'h4;
	localparam logic [3:0] ADDR_STATUS = 4'h8;
	localparam logic [3:0] ADDR_PEND = 4'hc;
	// Control register fields
	localparam int F_HALT_MODE = 0;
	localparam int F_WARM_SEL = 2;
	localparam int F_DRIVE_STOP = 3;
	localparam int F_IDLE_RUN = 4;
	localparam int F_TMR8_RUN = 4;
	localparam int F_TMRA_RUN = 5;
	localparam logic [7:0] CTRL_RESET = 8'h00;
	localparam logic [23:0] PRIO_RESET = 24'h000000;
endpackage

// File: core/ihw_prio_resolve.sv
// Highest-level pending request; among equals the lowest index wins
module ihw_prio_resolve
	import ihw_pkg::*;
#(
	parameter int N = 8
) (
	input wire logic [N-1:0] pend_i, // Pending flags
	input wire logic [3*N-1:0] level_i, // Level per source
	output logic found_o, // A usable request exists
	output logic [2:0] level_o, // Winning level
	output logic [$clog2(N)-1:0] idx_o // Winning source
);
	always_comb begin
		found_o = 1'b0;
		level_o = LEVEL_MIN;
		idx_o = '0;
		for (int i = 0; i < N; i++) begin
			// Levels 0 and 7 never request; strict compare keeps lowest index
			if (pend_i[i] && level_i[3*i +: 3] != LEVEL_MIN && level_i[3*i +: 3] != LEVEL_MAX
				&& (!found_o || level_i[3*i +: 3] > level_o)) begin
				found_o = 1'b1;
				level_o = level_i[3*i +: 3];
				idx_o = ($clog2(N))'(i);
			end
		end
	end
endmodule // ihw_prio_resolve

// File: testbench/ihw_cpu_model.sv
// CPU and wake-source stand-in facing the controller
module ihw_cpu_model (
	input wire logic clk_i, // System clock
	input wire logic rst_i, // Sync reset, high
	input wire logic accept_en_i, // Bench allows acceptance
	input wire logic irq_req_i, // Request from controller
	input wire logic push_ctx_i, // Acceptance under way
	input wire logic resume_i, // Halt released
	input wire logic wake_req_i, // Start a wake pin assertion
	output logic vec_read_o, // Vector read pulse
	output logic first_done_o, // First handler instruction done
	output logic wake_pin_o // Level-mode wake pin
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [2:0] busy_reg;

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			vec_read_o <= 1'b0;
			first_done_o <= 1'b0;
			busy_reg <= 3'h0;
			wake_pin_o <= 1'b0;
		end else begin
			// One vector read, then a quiet spell until the handler runs
			vec_read_o <= accept_en_i && irq_req_i && !vec_read_o && busy_reg == 3'h0;
			// Software entries start the handler without a vector read
			if (vec_read_o || (push_ctx_i && busy_reg == 3'h0)) begin
				busy_reg <= 3'h4;
			end else if (busy_reg != 3'h0) begin
				busy_reg <= busy_reg - 3'h1;
			end
			first_done_o <= busy_reg == 3'h3;
			// Pin held high until processing starts or halt ends
			if (wake_req_i) begin
				wake_pin_o <= 1'b1;
			end else if (push_ctx_i || resume_i) begin
				wake_pin_o <= 1'b0;
			end
		end
	end
endmodule // ihw_cpu_model

// File: testbench/interrupt_and_halt_wakeup_control_tb.sv
`define CHK(g, e) check_val(32'(g), 32'(e))
module interrupt_and_halt_wakeup_control_tb;
	timeunit 1ns;
	timeprecision 1ps;
	import ihw_pkg::*;
	localparam int WS = 4;
	localparam int WL = 8;
	localparam int DB = 4;
	logic clk_i = 1'b0;
	logic rst_i = 1'b1;
	logic [31:0] wb_adr = '0, wb_dat = '0, wb_dat_o, rd;
	logic wb_we = 1'b0, wb_cyc = 1'b0, wb_stb = 1'b0, wb_ack_o;
	logic [3:0] wb_sel = 4'h0;
	logic nmi = 1'b0, halt_exec = 1'b0, set_mask = 1'b0, mask_all = 1'b0, return_from_interrupt_instruction = 1'b0;
	logic sw_irq = 1'b0;
	logic accept_en = 1'b0, wake_req = 1'b0, vec_read, first_done, wake_pin;
	logic [7:0] pins = 8'h00;
	logic [2:0] set_mask_val = 3'h0, return_from_interrupt_instruction_mask = 3'h0;
	logic irq_req, push_ctx, pop_ctx, cpu_run, sys_clk_en, osc_en, periph_run, pin_drive_en, resume;
	logic [2:0] irq_level, mask_lvl;
	logic [7:0] vector, nest;
	logic [23:0] vector_addr;
	int miscompares = 0;
	int compares = 0;
	int cycles = 0;
	int n;

	always #25 clk_i = ~clk_i;

	ihw_ctrl #(.WARM_SHORT(WS), .WARM_LONG(WL), .DOUBLER(DB)) i_ihw_ctrl (
		.clk_i(clk_i), .rst_i(rst_i), .wb_adr_i(wb_adr), .wb_dat_i(wb_dat), .wb_dat_o(wb_dat_o),
		.wb_we_i(wb_we), .wb_sel_i(wb_sel), .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb),
		.wb_ack_o(wb_ack_o), .nmi_pin_i(nmi), .irq_pin_i({pins[7:1], wake_pin}),
		.halt_exec_i(halt_exec), .set_mask_i(set_mask), .set_mask_val_i(set_mask_val),
		.mask_all_i(mask_all), .sw_irq_i(sw_irq), .sw_num_i(3'h3), .illegal_i(1'b0),
		.vec_read_i(vec_read), .first_instr_done_i(first_done), .return_from_interrupt_instruction_i(return_from_interrupt_instruction),
		.return_from_interrupt_instruction_mask_i(return_from_interrupt_instruction_mask), .irq_req_o(irq_req), .irq_level_o(irq_level),
		.vector_o(vector), .vector_addr_o(vector_addr), .push_ctx_o(push_ctx),
		.pop_ctx_o(pop_ctx), .interrupt_mask_level_o(mask_lvl), .nesting_counter_o(nest),
		.cpu_run_o(cpu_run), .sys_clk_en_o(sys_clk_en), .osc_en_o(osc_en),
		.periph_run_o(periph_run), .pin_drive_en_o(pin_drive_en), .resume_o(resume)
	);

	ihw_cpu_model i_ihw_cpu_model (
		.clk_i(clk_i), .rst_i(rst_i), .accept_en_i(accept_en), .irq_req_i(irq_req),
		.push_ctx_i(push_ctx), .resume_i(resume), .wake_req_i(wake_req),
		.vec_read_o(vec_read), .first_done_o(first_done), .wake_pin_o(wake_pin)
	);

	task automatic check_val(input logic [31:0] g, input logic [31:0] e);
		compares++;
		if (g !== e) begin
			miscompares++;
			$display("mismatch at %0t got %h exp %h", $time, g, e);
		end
	endtask

	task automatic finish_test();
		$display("compares %0d miscompares %0d", compares, miscompares);
		if (miscompares == 0 && compares > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask

	always @(posedge clk_i) begin
		cycles <= cycles + 1;
		if (cycles == 5000) begin
			miscompares++;
			finish_test();
		end
	end

	// Classic single Wishbone cycle, waits for ack
	task automatic wb(input logic we, input logic [31:0] a, input logic [31:0] d);
		int k;
		@(posedge clk_i);
		wb_adr <= a;
		wb_dat <= d;
		wb_we <= we;
		wb_sel <= 4'hf;
		wb_cyc <= 1'b1;
		wb_stb <= 1'b1;
		k = 0;
		do begin
			@(posedge clk_i);
			k++;
		end while (wb_ack_o !== 1'b1 && k < 50);
		rd = wb_dat_o;
		wb_cyc <= 1'b0;
		wb_stb <= 1'b0;
		wb_we <= 1'b0;
		if (k >= 50) miscompares++;
	endtask

	task automatic accept_one(input logic [7:0] v, input logic [2:0] m);
		@(posedge clk_i);
		accept_en <= 1'b1;
		repeat (6) @(posedge clk_i);
		accept_en <= 1'b0;
		@(negedge clk_i);
		`CHK(vector, v);
		`CHK(vector_addr, VECTOR_BASE + 24'(v));
		`CHK(mask_lvl, m);
		`CHK(nest, 1);
		`CHK(irq_req, 0);
		@(posedge clk_i);
		return_from_interrupt_instruction_mask <= 3'h1;
		return_from_interrupt_instruction <= 1'b1;
		@(posedge clk_i);
		return_from_interrupt_instruction <= 1'b0;
		@(negedge clk_i);
		`CHK(nest, 0);
		`CHK(mask_lvl, 1);
	endtask

	task automatic halt(input logic [31:0] ctrl);
		wb(1'b1, 32'(ADDR_CTRL), ctrl);
		@(posedge clk_i);
		halt_exec <= 1'b1;
		@(posedge clk_i);
		halt_exec <= 1'b0;
		repeat (3) @(negedge clk_i);
	endtask

	// Cycles until the system clock comes back
	task automatic wait_clk();
		n = 0;
		while (sys_clk_en !== 1'b1 && n < 200) begin
			@(posedge clk_i);
			n++;
		end
		repeat (3) @(negedge clk_i);
	endtask

	initial begin
		repeat (10) @(posedge clk_i);
		rst_i <= 1'b0;
		@(negedge clk_i);
		`CHK(mask_lvl, MASK_RESET);
		`CHK({nest, cpu_run, sys_clk_en, osc_en, pin_drive_en}, 12'h00f);
		`CHK(vector_addr, VECTOR_BASE);
		wb(1'b0, 32'(ADDR_CTRL), 32'h0);
		`CHK(rd, CTRL_RESET);
		wb(1'b0, 32'h3, 32'h0);
		`CHK(rd, 0);
		$display("test reset done");

		// Levels: src1 3, src2 3, src3 2, src4 7
		wb(1'b1, 32'(ADDR_PRIO), 32'h74d8);
		@(posedge clk_i);
		set_mask_val <= 3'h0;
		set_mask <= 1'b1;
		@(posedge clk_i);
		set_mask <= 1'b0;
		@(negedge clk_i);
		`CHK(mask_lvl, 1);
		@(posedge clk_i);
		pins <= 8'h10;
		repeat (8) @(negedge clk_i);
		`CHK(irq_req, 0);
		@(posedge clk_i);
		pins <= 8'h1e;
		repeat (8) @(negedge clk_i);
		`CHK({irq_req, irq_level}, 4'hb);
		accept_one(8'h2c, 3'h4);
		wb(1'b0, 32'(ADDR_PEND), 32'h0);
		`CHK(rd[2:1], 2'b10);
		accept_one(8'h30, 3'h4);
		accept_one(8'h34, 3'h3);
		`CHK(irq_req, 0);
		wb(1'b1, 32'(ADDR_PEND), 32'h1ff);
		@(posedge clk_i);
		pins <= 8'h00;
		mask_all <= 1'b1;
		@(posedge clk_i);
		mask_all <= 1'b0;
		@(negedge clk_i);
		`CHK(mask_lvl, 7);
		@(posedge clk_i);
		sw_irq <= 1'b1;
		@(posedge clk_i);
		sw_irq <= 1'b0;
		@(negedge clk_i);
		`CHK(vector_addr, VECTOR_BASE + 24'h00000c);
		`CHK({push_ctx, nest, mask_lvl}, 12'h80f);
		repeat (4) @(posedge clk_i);
		return_from_interrupt_instruction_mask <= 3'h7;
		return_from_interrupt_instruction <= 1'b1;
		@(posedge clk_i);
		return_from_interrupt_instruction <= 1'b0;
		@(negedge clk_i);
		`CHK({pop_ctx, nest, mask_lvl}, 12'h807);
		@(posedge clk_i);
		set_mask_val <= 3'h1;
		set_mask <= 1'b1;
		@(posedge clk_i);
		set_mask <= 1'b0;
		$display("test priority done");

		// Stop, long warm-up, pins floating
		halt(32'h05);
		`CHK({cpu_run, sys_clk_en, osc_en, pin_drive_en}, 4'h0);
		`CHK(pin_drive_en, 0);
		@(posedge clk_i);
		pins <= 8'h08;
		repeat (12) @(negedge clk_i);
		`CHK(sys_clk_en, 0);
		wb(1'b1, 32'(ADDR_PEND), 32'h8);
		@(posedge clk_i);
		wake_req <= 1'b1;
		@(posedge clk_i);
		wake_req <= 1'b0;
		wait_clk();
		`CHK(n >= WL + DB && n < 200, 1);
		`CHK({cpu_run, osc_en, irq_req}, 3'h6);
		wb(1'b0, 32'(ADDR_PEND), 32'h0);
		`CHK(rd[0], 1);
		wb(1'b1, 32'(ADDR_PEND), 32'h1ff);
		@(posedge clk_i);
		pins <= 8'h00;
		$display("test stop done");

		// Clock idle, released by the non-maskable pin
		halt(32'h0a);
		`CHK({osc_en, sys_clk_en, cpu_run}, 3'h4);
		@(posedge clk_i);
		nmi <= 1'b1;
		wait_clk();
		`CHK(n >= WS && n < 200, 1);
		`CHK({cpu_run, irq_req, irq_level}, 5'h1f);
		wb(1'b1, 32'(ADDR_PEND), 32'h100);
		@(posedge clk_i);
		nmi <= 1'b0;
		$display("test clock idle done");

		// Peripheral idle, pin five sets timer idle-run bits
		halt(32'h03);
		`CHK({cpu_run, sys_clk_en, periph_run}, 3'h2);
		@(posedge clk_i);
		pins <= 8'h20;
		repeat (8) @(negedge clk_i);
		wb(1'b0, 32'(ADDR_CTRL), 32'h0);
		`CHK(rd[5:4], 2'b11);
		`CHK(periph_run, 1);
		@(posedge clk_i);
		nmi <= 1'b1;
		repeat (12) @(negedge clk_i);
		`CHK(cpu_run, 1);
		wb(1'b1, 32'(ADDR_PEND), 32'h1ff);
		@(posedge clk_i);
		nmi <= 1'b0;
		pins <= 8'h00;
		$display("test peripheral idle done");

		// Reset while stopped
		halt(32'h01);
		`CHK(osc_en, 0);
		@(posedge clk_i);
		rst_i <= 1'b1;
		repeat (2) @(posedge clk_i);
		rst_i <= 1'b0;
		@(negedge clk_i);
		`CHK({cpu_run, sys_clk_en, osc_en, mask_lvl}, 6'h3f);
		$display("test reset in stop done");
		finish_test();
	end
endmodule // interrupt_and_halt_wakeup_control_tb
